// ===== servo_brake_pkg.sv
`default_nettype none

package servo_brake_pkg;

    // ----------------------------------------------------------------
    // stop modes
    // ----------------------------------------------------------------
    localparam logic [1:0] MODE_DB_HOLD = 2'h0;
    localparam logic [1:0] MODE_DB_COAST = 2'h1;
    localparam logic [1:0] MODE_FREE_RUN = 2'h2;

    // ----------------------------------------------------------------
    // timing
    // ----------------------------------------------------------------
    localparam int CLK_FREQ_HZ = 25_000_000;
    localparam int TICK_PERIOD_MS = 10;
    localparam int TICK_CYCLES = CLK_FREQ_HZ / 1000 * TICK_PERIOD_MS;
    localparam int TICK_COUNT_W = 7;

    // ----------------------------------------------------------------
    // setting ranges and defaults
    // ----------------------------------------------------------------
    localparam int DELAY_W = 6;
    localparam logic [DELAY_W-1:0] DELAY_MAX = 6'h32;
    localparam logic [DELAY_W-1:0] DELAY_DEFAULT = 6'h00;
    localparam logic [TICK_COUNT_W-1:0] TIMEOUT_MIN = 7'h0a;
    localparam logic [TICK_COUNT_W-1:0] TIMEOUT_MAX = 7'h64;
    localparam logic [TICK_COUNT_W-1:0] TIMEOUT_DEFAULT = 7'h32;
    localparam int SPEED_W = 14;
    localparam logic [SPEED_W-1:0] THRESH_MAX = 14'h2710;
    localparam logic [SPEED_W-1:0] THRESH_DEFAULT = 14'h0064;
    localparam logic [SPEED_W-1:0] LOW_SPEED_DEFAULT = 14'h000a;

    // ----------------------------------------------------------------
    // output selection field
    // ----------------------------------------------------------------
    localparam int SEL_W = 16;
    localparam logic [SEL_W-1:0] SEL_DEFAULT = 16'h0000;
    localparam int BRAKE_DIGIT_LSB = 8;
    localparam int CIRCUITS = 3;

    typedef enum logic [1:0] {
        ST_ON = 2'b00,
        ST_HOLD = 2'b01,
        ST_OFF = 2'b11,
        ST_RUN = 2'b10
    } servo_state_type;

endpackage

`default_nettype wire

// ===== tick_divider.sv
`default_nettype none

module tick_divider
    import servo_brake_pkg::*;
#(
    parameter int CYCLES = TICK_CYCLES
)
(
    // clock and reset
    input wire logic clk,
    input wire logic srst,
    // control
    input wire logic clr,
    // tick
    output logic tick
);

    localparam int CW = $clog2(CYCLES);

    if (CYCLES < 2)
    begin : g_bad_cycles
        $error("tick_divider: CYCLES must be at least 2");
    end

    logic [CW-1:0] count;
    wire wrap = (count == CW'(CYCLES - 1));

    // ----------------------------------------------------------------
    // free count, restarted so that a period starts at the event
    // ----------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (srst || clr || wrap)
            count <= '0;
        else
            count <= count + 1'b1;
    end

    always_ff @(posedge clk)
    begin
        if (srst)
            tick <= 1'b0;
        else
            tick <= wrap && !clr;
    end

endmodule // tick_divider

`default_nettype wire

// ===== servo_stop_brake_sequencer.sv
// Notes on behaviour
// - Mode 0: dynamic brake stops motor and stays shorted afterwards.
// - Mode 1: dynamic brake stops motor, then opens so motor coasts.
// - Mode 2, reset default: motor off without dynamic brake, free run.
// - Servo off on off command, any alarm, or power loss.
// - Motor already stopped or near stopped: dynamic brake modes act as free run.
// - Both powers off: dynamic brake shorted even in free-run mode.
// - Brake output active releases holding brake; inactive applies it.
// - Selection digit 0 unallocated; 1 to 3 pick one of three circuits.
// - Functions sharing one circuit drive it with their OR.
// - Sequence enable 1 ignores delay, threshold and timeout settings.
// - Standstill: servo off follows brake apply by delay, 10 ms units, 0..50.
// - Delay zero: servo off together with brake apply.
// - Standstill delay only when stopped; threshold and timeout while moving.
// - Alarm cuts motor output at once, no standstill delay.
// - Running brake timing applies on off command or alarm while moving.
// - Running: brake applied on first of speed or timeout condition.
// - Speed condition: speed below threshold, r/min, 0..10000, default 100.
// - Timeout condition: elapsed since servo off, 10 ms units, 10..100.
// - Threshold above maximum speed uses the maximum speed.
`default_nettype none

module servo_stop_brake_sequencer
    import servo_brake_pkg::*;
#(
    parameter int TICK_LEN = TICK_CYCLES,
    parameter logic [SPEED_W-1:0] LOW_SPEED = LOW_SPEED_DEFAULT
)
(
    // clock and reset
    input wire logic clk,
    input wire logic srst,
    // servo commands and faults
    input wire logic servo_on_command,
    input wire logic servo_off_command,
    input wire logic servo_alarm,
    input wire logic main_power_off,
    input wire logic control_power_off,
    // motor feedback, r/min magnitude
    input wire logic [SPEED_W-1:0] motor_speed,
    input wire logic [SPEED_W-1:0] motor_max_speed,
    // settings
    input wire logic [1:0] stop_mode_select,
    input wire logic brake_sequence_enable,
    input wire logic [DELAY_W-1:0] standstill_brake_delay,
    input wire logic [SPEED_W-1:0] brake_speed_threshold,
    input wire logic [TICK_COUNT_W-1:0] running_brake_timeout,
    input wire logic [SEL_W-1:0] output_signal_select_two,
    // other output functions, digits 0, 1 and 3
    input wire logic [2:0] aux_output_function,
    // drive outputs
    output logic motor_output_enable,
    output logic dynamic_brake_short,
    output logic brake_release_output,
    output logic servo_is_on,
    output logic [CIRCUITS-1:0] out_circuit_n
);

    if (TICK_LEN < 2 || LOW_SPEED > THRESH_MAX)
    begin : g_bad_params
        $error("servo_stop_brake_sequencer: unusable parameter values");
    end

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    servo_state_type state;
    servo_state_type next_state;
    logic [TICK_COUNT_W-1:0] tick_count;
    logic db_allowed;
    logic coast_done;
    logic tick;

    // ----------------------------------------------------------------
    // conditions
    // ----------------------------------------------------------------
    wire stopped = (motor_speed <= LOW_SPEED);
    wire both_off = main_power_off && control_power_off;
    wire power_fail = main_power_off || control_power_off;
    wire abrupt = servo_alarm || power_fail;
    wire seq_dis = brake_sequence_enable;
    wire off_event = (state == ST_ON) && (servo_off_command || abrupt);
    wire start_ok = servo_on_command && !servo_off_command && !abrupt;

    wire [DELAY_W-1:0] delay_eff =
        (standstill_brake_delay > DELAY_MAX) ? DELAY_MAX : standstill_brake_delay;
    wire [TICK_COUNT_W-1:0] timeout_eff =
        (running_brake_timeout < TIMEOUT_MIN) ? TIMEOUT_MIN :
        (running_brake_timeout > TIMEOUT_MAX) ? TIMEOUT_MAX : running_brake_timeout;
    wire [SPEED_W-1:0] thr_cap =
        (brake_speed_threshold > THRESH_MAX) ? THRESH_MAX : brake_speed_threshold;
    wire [SPEED_W-1:0] thr_eff =
        (thr_cap > motor_max_speed) ? motor_max_speed : thr_cap;

    wire delay_done = (tick_count >= {1'b0, delay_eff});
    wire timeout_hit = (tick_count >= timeout_eff);
    wire speed_hit = (motor_speed < thr_eff);

    // ----------------------------------------------------------------
    // sequencing
    // ----------------------------------------------------------------
    always_comb
    begin
        next_state = state;
        case (state)
            ST_ON:
            begin
                if (off_event)
                begin
                    if (seq_dis)
                        next_state = ST_OFF;
                    else if (stopped && (abrupt || delay_eff == '0))
                        next_state = ST_OFF;
                    else if (stopped)
                        next_state = ST_HOLD;
                    else
                        next_state = ST_RUN;
                end
            end
            ST_HOLD:
            begin
                if (abrupt || seq_dis || delay_done)
                    next_state = ST_OFF;
            end
            ST_RUN:
            begin
                if (seq_dis || speed_hit || timeout_hit)
                    next_state = ST_OFF;
            end
            ST_OFF:
            begin
                if (start_ok)
                    next_state = ST_ON;
            end
            default:
            begin
                next_state = ST_OFF;
            end
        endcase
    end

    wire next_off_side = (next_state == ST_RUN) || (next_state == ST_OFF);
    wire next_db_allowed = off_event ? !stopped : db_allowed;
    wire next_coast = off_event ? 1'b0 : (coast_done || (state != ST_ON && stopped));
    wire next_motor = (next_state == ST_ON) || (next_state == ST_HOLD);
    wire next_release = (next_state == ST_ON) || (next_state == ST_RUN);

    logic next_db;
    always_comb
    begin
        next_db = 1'b0;
        if (both_off)
            next_db = 1'b1;
        else if (next_off_side)
        begin
            case (stop_mode_select)
                MODE_DB_HOLD: next_db = next_db_allowed;
                MODE_DB_COAST: next_db = next_db_allowed && !next_coast;
                default: next_db = 1'b0;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // output circuit routing
    // ----------------------------------------------------------------
    wire [3:0] func_active = {aux_output_function[2], next_release,
        aux_output_function[1:0]};
    logic [CIRCUITS-1:0] next_circuit;

    for (genvar c = 0; c < CIRCUITS; c++)
    begin : g_circuit
        wire [3:0] hit;
        for (genvar f = 0; f < 4; f++)
        begin : g_func
            assign hit[f] = func_active[f] &&
                (output_signal_select_two[4*f +: 4] == 4'(c + 1));
        end
        assign next_circuit[c] = |hit;
    end

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    tick_divider #(
        .CYCLES(TICK_LEN)
    ) u_tick (
        .clk(clk),
        .srst(srst),
        .clr(off_event),
        .tick(tick)
    );

    always_ff @(posedge clk)
    begin
        if (srst)
            state <= ST_OFF;
        else
            state <= next_state;
    end

    always_ff @(posedge clk)
    begin
        if (srst || off_event)
            tick_count <= '0;
        else if (tick && tick_count != '1)
            tick_count <= tick_count + 1'b1;
    end

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            db_allowed <= 1'b0;
            coast_done <= 1'b0;
        end
        else
        begin
            db_allowed <= next_db_allowed;
            coast_done <= next_coast;
        end
    end

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            motor_output_enable <= 1'b0;
            dynamic_brake_short <= 1'b0;
            brake_release_output <= 1'b0;
            servo_is_on <= 1'b0;
            out_circuit_n <= '1;
        end
        else
        begin
            motor_output_enable <= next_motor;
            dynamic_brake_short <= next_db;
            brake_release_output <= next_release;
            servo_is_on <= (next_state == ST_ON);
            out_circuit_n <= ~next_circuit;
        end
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (srst);

    sequence off_request;
        state == ST_ON && off_event;
    endsequence

    sequence stopped_request;
        off_request ##0 stopped && !seq_dis;
    endsequence

    sequence moving_request;
        off_request ##0 !stopped && !seq_dis;
    endsequence

    a_alarm_motor_cut: assert property (
        (off_request ##0 servo_alarm) |=> !motor_output_enable)
        else $error("alarm did not cut motor output");

    a_zero_delay_off: assert property (
        (stopped_request ##0 delay_eff == '0) |=> state == ST_OFF && !motor_output_enable && !brake_release_output)
        else $error("zero delay did not turn servo off with brake");

    a_hold_keeps_motor: assert property (
        (stopped_request ##0 !abrupt && delay_eff != '0)
            |=> state == ST_HOLD && motor_output_enable && !brake_release_output)
        else $error("standstill delay not entered");

    a_run_on_speed: assert property (
        (state == ST_RUN && !seq_dis && speed_hit) |=> state == ST_OFF && !brake_release_output)
        else $error("speed condition did not apply brake");

    a_run_timeout: assert property (
        (state == ST_RUN && tick_count >= timeout_eff) |=> state == ST_OFF)
        else $error("timeout did not end running wait");

    a_seq_disable: assert property (
        (off_request ##0 seq_dis) |=> state == ST_OFF && !motor_output_enable)
        else $error("sequence disable did not stop at once");

    a_on_release: assert property (
        state == ST_ON |-> brake_release_output && motor_output_enable && !dynamic_brake_short)
        else $error("servo on without brake release");

    a_free_run_db: assert property (
        (stop_mode_select == MODE_FREE_RUN && !both_off) |=> !dynamic_brake_short)
        else $error("dynamic brake used in free-run mode");

    a_power_db: assert property (
        both_off |=> dynamic_brake_short)
        else $error("dynamic brake missing on full power loss");

    a_route_brake: assert property (
        (next_release && output_signal_select_two[11:8] == 4'h1) |=> !out_circuit_n[0])
        else $error("brake release not routed to circuit one");

    a_run_wait_entry: assert property (
        moving_request |=> state == ST_RUN && brake_release_output && !motor_output_enable)
        else $error("running servo off did not wait with brake released");

    a_run_db_stop: assert property (
        (moving_request ##0 (stop_mode_select == MODE_DB_HOLD || stop_mode_select == MODE_DB_COAST))
            |=> dynamic_brake_short)
        else $error("dynamic brake missing on running stop");

    a_db_hold_kept: assert property (
        (state == ST_OFF && !start_ok && db_allowed && stop_mode_select == MODE_DB_HOLD) |=> dynamic_brake_short)
        else $error("dynamic brake not kept after stop");

    a_coast_release: assert property (
        (state != ST_ON && stopped && !both_off && stop_mode_select == MODE_DB_COAST) |=> !dynamic_brake_short)
        else $error("dynamic brake not released for coasting");

    a_stopped_no_db: assert property (
        (off_request ##0 stopped && !both_off) |=> !dynamic_brake_short)
        else $error("dynamic brake used on a stopped motor");

    a_hold_waits: assert property (
        (state == ST_HOLD && !abrupt && !seq_dis && !delay_done) |=> state == ST_HOLD && motor_output_enable)
        else $error("standstill delay cut short");

    a_hold_alarm_cut: assert property (
        (state == ST_HOLD && abrupt) |=> state == ST_OFF && !motor_output_enable)
        else $error("alarm did not end standstill delay");

    a_run_keeps_release: assert property (
        (state == ST_RUN && !seq_dis && !speed_hit && !timeout_hit) |=> state == ST_RUN && brake_release_output)
        else $error("brake applied before speed or timeout condition");

    a_threshold_cap: assert property (
        (state == ST_RUN && !seq_dis && !timeout_hit && motor_speed >= motor_max_speed) |=> state == ST_RUN)
        else $error("threshold above maximum speed ended running wait");

    a_tick_restart: assert property (
        off_event |=> tick_count == '0 && !tick)
        else $error("tick count not restarted at servo off");

endmodule // servo_stop_brake_sequencer

`default_nettype wire

// ===== brake_relay_model.sv
`default_nettype none

// ----------------------------------------------------------------
// external brake relay and holding brake
// ----------------------------------------------------------------
module brake_relay_model
#(
    parameter int LAG = 2
)
(
    // clock
    input wire logic clk,
    // relay coil circuit, low = closed
    input wire logic circuit_n,
    // brake state
    output logic brake_held
);
    timeunit 1ns;
    timeprecision 1ns;

    logic [LAG-1:0] pipe = '1;

    // coil energised only while closed; the spring holds the brake otherwise
    always_ff @(posedge clk)
    begin
        pipe <= {pipe[LAG-2:0], circuit_n};
    end

    assign brake_held = pipe[LAG-1];
endmodule // brake_relay_model

`default_nettype wire

// ===== servo_stop_brake_sequencer_bench.sv
`default_nettype none

module servo_stop_brake_sequencer_bench
    import servo_brake_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

    // ----------------------------------------------------------------
    // signals
    // ----------------------------------------------------------------
    localparam int TL = 4;
    logic clk = 1'b0;
    logic srst, on_cmd, off_cmd, alarm, main_off, ctrl_off, seq_en, brake_held;
    logic [SPEED_W-1:0] speed, max_speed, thr;
    logic [1:0] mode;
    logic [DELAY_W-1:0] dly;
    logic [TICK_COUNT_W-1:0] tmo;
    logic [SEL_W-1:0] sel;
    logic [2:0] aux;
    logic motor_en, db, brake, is_on;
    logic [CIRCUITS-1:0] circ_n;
    int failures = 0;
    int samples_checked = 0;
    int cycles = 0;

    servo_stop_brake_sequencer #(.TICK_LEN(TL)) dut
    (
        .clk(clk), .srst(srst), .servo_on_command(on_cmd), .servo_off_command(off_cmd),
        .servo_alarm(alarm), .main_power_off(main_off), .control_power_off(ctrl_off),
        .motor_speed(speed), .motor_max_speed(max_speed), .stop_mode_select(mode),
        .brake_sequence_enable(seq_en), .standstill_brake_delay(dly), .brake_speed_threshold(thr),
        .running_brake_timeout(tmo), .output_signal_select_two(sel), .aux_output_function(aux),
        .motor_output_enable(motor_en), .dynamic_brake_short(db), .brake_release_output(brake),
        .servo_is_on(is_on), .out_circuit_n(circ_n)
    );

    brake_relay_model #(.LAG(2)) relay (.clk(clk), .circuit_n(circ_n[1]), .brake_held(brake_held));

    // ----------------------------------------------------------------
    // clock, hang guard, helpers
    // ----------------------------------------------------------------
    initial
    begin
        forever #20 clk = ~clk;
    end

    always @(posedge clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 6000)
        begin
            failures++;
            final_report();
        end
    end

    task automatic final_report();
        $display("checks %0d, mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string msg);
        samples_checked++;
        if (seen !== exp)
        begin
            failures++;
            $display("CHECK FAILED at %0t: %s", $time, msg);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask

    // every test begins from reset, never by rapid on/off cycling
    task automatic start(input logic [1:0] m, input logic [DELAY_W-1:0] d);
        srst = 1'b1;
        {on_cmd, off_cmd, alarm, main_off, ctrl_off, seq_en} = 6'h00;
        mode = m;
        dly = d;
        speed = 14'h0000;
        max_speed = 14'h1770;
        thr = THRESH_DEFAULT;
        tmo = TIMEOUT_DEFAULT;
        sel = 16'h0200;
        aux = 3'h0;
        cyc(4);
        check({motor_en, db, brake, is_on, circ_n}, 7'h07, "reset values");
        srst = 1'b0;
        on_cmd = 1'b1;
        cyc(1);
        on_cmd = 1'b0;
        check({is_on, motor_en, brake, circ_n}, 6'h3d, "servo on");
    endtask

    task automatic off_pulse();
        off_cmd = 1'b1;
        cyc(1);
        off_cmd = 1'b0;
    endtask

    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic t_standstill(input logic [DELAY_W-1:0] d);
        start(MODE_FREE_RUN, d);
        off_pulse();
        check(brake, 1'b0, "brake applied at stop");
        check(motor_en, d != 0, "motor at brake apply");
        if (d != 0)
        begin
            cyc(TL * d - 3);
            check(motor_en, 1'b1, "motor held in delay");
            for (int i = 0; i < 6 && motor_en; i++)
                cyc(1);
            check({motor_en, db}, 2'h0, "motor off after delay");
        end
        $display("test done: standstill %0d", d);
    endtask

    task automatic t_running(input logic [1:0] m);
        start(m, 6'h05);
        speed = 14'h03e8;
        cyc(2);
        check(brake_held, 1'b0, "relay released");
        off_pulse();
        check({motor_en, db, brake}, {1'b0, m < 2, 1'b1}, "running off");
        cyc(5);
        check(brake, 1'b1, "brake waits for speed");
        speed = 14'h0032;
        cyc(2);
        check({db, brake}, {m < 2, 1'b0}, "below threshold");
        speed = 14'h0000;
        cyc(2);
        check({db, brake_held}, {m == 0, 1'b1}, "after stop");
        $display("test done: running mode %0d", m);
    endtask

    task automatic t_timeout();
        start(MODE_FREE_RUN, 6'h00);
        tmo = 7'h05;
        speed = 14'h03e8;
        off_pulse();
        cyc(10 * TL - 4);
        check(brake, 1'b1, "before timeout");
        for (int i = 0; i < 8 && brake; i++)
            cyc(1);
        check(brake, 1'b0, "after timeout");
        $display("test done: timeout");
    endtask

    task automatic t_faults();
        start(MODE_FREE_RUN, 6'h05);
        alarm = 1'b1;
        cyc(1);
        check({motor_en, brake}, 2'h0, "alarm off");
        start(MODE_DB_HOLD, 6'h00);
        off_pulse();
        check(db, 1'b0, "stopped acts as free run");
        start(MODE_FREE_RUN, 6'h00);
        speed = 14'h03e8;
        {main_off, ctrl_off} = 2'b11;
        cyc(1);
        check({motor_en, db}, 2'h1, "power loss brake");
        start(MODE_FREE_RUN, 6'h05);
        seq_en = 1'b1;
        speed = 14'h03e8;
        off_pulse();
        check({motor_en, brake}, 2'h0, "sequence disabled");
        start(MODE_FREE_RUN, 6'h00);
        {thr, max_speed, speed} = {14'h1388, 14'h0bb8, 14'h0fa0};
        off_pulse();
        cyc(3);
        check(brake, 1'b1, "threshold capped");
        start(MODE_DB_HOLD, 6'h05);
        off_pulse();
        check({motor_en, db, brake}, 3'h4, "standstill hold");
        alarm = 1'b1;
        cyc(1);
        check({motor_en, db, brake}, 3'h0, "alarm ends hold");
        start(MODE_DB_COAST, 6'h05);
        speed = 14'h03e8;
        alarm = 1'b1;
        cyc(1);
        check({motor_en, db, brake}, 3'h3, "alarm while moving");
        speed = 14'h0000;
        cyc(2);
        check({db, brake}, 2'h0, "alarm stop coasts");
        $display("test done: faults");
    endtask

    task automatic t_route();
        logic [2:0] exp;
        start(MODE_FREE_RUN, 6'h00);
        for (int d = 0; d < 4; d++)
        begin
            sel = 16'(d) << 8;
            exp = (d == 0) ? 3'h7 : 3'(~(3'h1 << (d - 1)));
            cyc(1);
            check(circ_n, exp, "brake routing");
        end
        sel = 16'h0303;
        aux = 3'h1;
        off_pulse();
        check(circ_n, 3'h3, "shared circuit");
        aux = 3'h0;
        cyc(1);
        check(circ_n, 3'h7, "shared circuit idle");
        $display("test done: routing");
    endtask

    initial
    begin
        t_standstill(6'h00);
        t_standstill(6'h02);
        for (int m = 0; m < 4; m++)
            t_running(2'(m));
        t_timeout();
        t_faults();
        t_route();
        final_report();
    end
endmodule // servo_stop_brake_sequencer_bench

`default_nettype wire
